/* hw/mvl_fid_calc.sv */
`timescale 1ns/10ps
module mvl_fid_calc (
   input wire logic [mvl_pkg::VID_W-1:0] i_vid,
   input wire logic [1:0] i_filter_id_select,
   input wire logic [mvl_pkg::FID_W-1:0] i_override_filter_id_value,
   input wire logic [mvl_pkg::VID_W-1:0] i_mapped_filter_id_value,
   input wire logic [mvl_pkg::VID_W-1:0] i_vid_merge_mask,
   output logic [mvl_pkg::FID_W-1:0] o_dmac_fid,
   output logic [mvl_pkg::FID_W-1:0] o_smac_fid
);
   logic [mvl_pkg::FID_W-1:0] masked;
   logic [mvl_pkg::FID_W-1:0] base;
   logic map_hit;

   // Masked VID with a zero top bit
   assign masked = {1'b0, i_vid & ~i_vid_merge_mask};
   assign map_hit = (i_mapped_filter_id_value != 12'h000);

   // Map wins over mask unless the classifier overrides the frame
   always_comb begin
      if (i_filter_id_select != mvl_pkg::SEL_NONE) begin
         base = masked;
      end else if (map_hit) begin
         base = {1'b0, i_mapped_filter_id_value};
      end else begin
         base = masked;
      end
   end

   // Override per selected lookup
   always_comb begin
      o_dmac_fid = base;
      o_smac_fid = base;
      if (i_filter_id_select[0]) begin
         o_dmac_fid = i_override_filter_id_value;
      end
      if (i_filter_id_select[1]) begin
         o_smac_fid = i_override_filter_id_value;
      end
   end
endmodule : mvl_fid_calc

/* hw/mvl_ram.sv */
`timescale 1ns/10ps
module mvl_ram #(
   parameter int W = 8,
   parameter int AW = 4
) (
   input wire logic i_clk,
   mvl_ram_if.ram bus
);
   logic [W-1:0] mem [0:(1<<AW)-1];

   // Refuse shapes the table cannot hold
   if (W < 1 || AW < 1 || AW > 16) begin : g_chk
      $error("mvl_ram: unsupported width or depth");
   end

   // Single write port, frozen with the clock enable
   always_ff @(posedge i_clk) begin
      if (bus.ce && bus.we) begin
         mem[bus.waddr] <= bus.wdata;
      end
   end

   // Both read ports come out of registers
   always_ff @(posedge i_clk) begin
      if (bus.ce) begin
         bus.rdata_a <= mem[bus.raddr_a];
         bus.rdata_b <= mem[bus.raddr_b];
      end
   end
endmodule : mvl_ram

/* hw/mvl_top.sv */
`timescale 1ns/10ps
module mvl_top #(
   parameter int NPORTS = mvl_pkg::NPORTS,
   parameter int CNT_W = mvl_pkg::CNT_W,
   parameter int HOST_PORT = mvl_pkg::HOST_PORT
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_ce,
   // Age-search filter configuration
   input wire logic i_age_search_filter_ena,
   input wire logic i_filt_port_ena,
   input wire logic [mvl_pkg::PORT_W-1:0] i_filt_port,
   input wire logic i_filt_fid_ena,
   input wire logic [mvl_pkg::FID_W-1:0] i_filt_fid,
   input wire logic i_filt_dom_ena,
   input wire logic i_filt_dom,
   // Entry offered by a scan
   input wire logic i_scan_valid,
   input wire logic [1:0] i_scan_op,
   input wire logic [mvl_pkg::PORT_W-1:0] i_scan_port,
   input wire logic [mvl_pkg::FID_W-1:0] i_scan_fid,
   input wire logic i_scan_dom,
   output logic o_scan_valid,
   output logic o_scan_act,
   // Frame classification
   input wire logic i_frame_valid,
   input wire logic [mvl_pkg::VID_W-1:0] i_frame_vid,
   input wire logic [mvl_pkg::PORT_W-1:0] i_physical_ingress_port,
   input wire logic [1:0] i_filter_id_select,
   input wire logic [mvl_pkg::FID_W-1:0] i_override_filter_id_value,
   input wire logic [mvl_pkg::VID_W-1:0] i_vid_merge_mask,
   output logic o_res_valid,
   output logic [mvl_pkg::FID_W-1:0] o_dmac_fid,
   output logic [mvl_pkg::FID_W-1:0] o_learn_fid,
   output logic [NPORTS-1:0] o_member_port_mask,
   output logic o_mirror_on_receive,
   output logic o_learning_off_flag,
   output logic o_private_flag,
   output logic o_ingress_drop,
   // Per-VID filter-id map writes
   input wire logic i_map_we,
   input wire logic [mvl_pkg::VID_W-1:0] i_map_vid,
   input wire logic [mvl_pkg::VID_W-1:0] i_mapped_filter_id_value,
   // Learn limit
   input wire logic [NPORTS*CNT_W-1:0] i_port_entry_limit,
   input wire logic [NPORTS-1:0] i_limit_copy,
   input wire logic [NPORTS-1:0] i_limit_discard,
   input wire logic i_learn_valid,
   input wire logic i_learn_host,
   input wire logic [mvl_pkg::PORT_W-1:0] i_learn_port,
   input wire logic i_learn_locked,
   input wire logic i_learn_ip_multicast_entry,
   input wire logic i_learn_move,
   input wire logic [mvl_pkg::PORT_W-1:0] i_learn_old_port,
   input wire logic i_remove_valid,
   input wire logic [mvl_pkg::PORT_W-1:0] i_remove_port,
   output logic o_learn_done,
   output logic o_learn_accept,
   output logic o_learn_refuse,
   output logic o_move_delete,
   output logic o_limit_copy_host,
   output logic o_limit_withhold_fwd,
   output logic [NPORTS*CNT_W-1:0] o_port_entry_count,
   output logic [mvl_pkg::DISC_W-1:0] o_learn_discard_counter,
   // VLAN table command port
   input wire logic i_vlan_cmd_wr,
   input wire logic [1:0] i_vlan_table_command,
   input wire logic [mvl_pkg::VID_W-1:0] i_vlan_index,
   input wire logic [NPORTS-1:0] i_member_port_mask,
   input wire logic [mvl_pkg::FLAG_W-1:0] i_vlan_flags,
   output logic [1:0] o_vlan_table_command,
   output logic [mvl_pkg::VID_W-1:0] o_vlan_rd_index,
   output logic [NPORTS-1:0] o_vlan_rd_mask,
   output logic [mvl_pkg::FLAG_W-1:0] o_vlan_rd_flags
);
   localparam int AW = mvl_pkg::VID_W;
   localparam int EW = mvl_pkg::ENTRY_W;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_INIT = 3'b001,
      ST_WRITE = 3'b010,
      ST_RD_ADDR = 3'b011,
      ST_RD_CAP = 3'b100
   } mvl_state_e;

   // Refuse shapes the packed fields cannot serve
   if (NPORTS != mvl_pkg::NPORTS || HOST_PORT >= NPORTS || CNT_W < 1) begin : g_chk
      $error("mvl_top: unsupported port count, host port or counter width");
   end

   mvl_state_e state;
   mvl_state_e next_state;
   logic [AW-1:0] init_addr;
   logic [AW-1:0] cmd_index;
   logic [EW-1:0] cmd_entry;
   logic [CNT_W-1:0] cnt [NPORTS];
   logic [CNT_W-1:0] next_cnt [NPORTS];
   logic f1_valid;
   logic f1_init;
   logic [mvl_pkg::VID_W-1:0] f1_vid;
   logic [mvl_pkg::PORT_W-1:0] f1_port;
   logic [1:0] f1_sel;
   logic [mvl_pkg::FID_W-1:0] f1_ovr;
   logic [mvl_pkg::VID_W-1:0] f1_mask;
   logic [EW-1:0] f1_entry;
   logic [NPORTS-1:0] f1_members;
   logic [mvl_pkg::FID_W-1:0] calc_dmac;
   logic [mvl_pkg::FID_W-1:0] calc_smac;
   logic counted;
   logic refuse;
   logic inc_new;
   logic dec_old;

   mvl_ram_if #(.W(EW), .AW(AW)) vtab ();
   mvl_ram_if #(.W(mvl_pkg::VID_W), .AW(AW)) fmap ();

   mvl_ram #(.W(EW), .AW(AW)) u_vlan_ram (
      .i_clk(i_clk),
      .bus(vtab.ram)
   );

   mvl_ram #(.W(mvl_pkg::VID_W), .AW(AW)) u_map_ram (
      .i_clk(i_clk),
      .bus(fmap.ram)
   );

   mvl_fid_calc u_fid (
      .i_vid(f1_vid),
      .i_filter_id_select(f1_sel),
      .i_override_filter_id_value(f1_ovr),
      .i_mapped_filter_id_value(fmap.rdata_a),
      .i_vid_merge_mask(f1_mask),
      .o_dmac_fid(calc_dmac),
      .o_smac_fid(calc_smac)
   );

   // Port index within the table
   function automatic logic in_range(input logic [mvl_pkg::PORT_W-1:0] p);
      in_range = (int'(p) < NPORTS);
   endfunction : in_range

   // Limit of one port
   function automatic logic [CNT_W-1:0] lim_of(input logic [mvl_pkg::PORT_W-1:0] p);
      lim_of = i_port_entry_limit[int'(p)*CNT_W +: CNT_W];
   endfunction : lim_of

   // Age-search filter, all enabled criteria must agree
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_scan_valid <= 1'b0;
         o_scan_act <= 1'b0;
      end else if (i_ce) begin
         o_scan_valid <= i_scan_valid;
         if (i_age_search_filter_ena && (i_scan_op != mvl_pkg::SCAN_OTHER)) begin
            o_scan_act <= (!i_filt_port_ena || (i_scan_port == i_filt_port)) &&
               (!i_filt_fid_ena || (i_scan_fid == i_filt_fid)) &&
               (!i_filt_dom_ena || (i_scan_dom == i_filt_dom));
         end else begin
            o_scan_act <= 1'b1;
         end
      end
   end

   // Map memory: frame lookup on port A, host writes
   assign fmap.ce = i_ce;
   assign fmap.we = i_map_we;
   assign fmap.waddr = i_map_vid;
   assign fmap.wdata = i_mapped_filter_id_value;
   assign fmap.raddr_a = i_frame_vid;
   assign fmap.raddr_b = i_map_vid;

   // VLAN memory: frames on port A, host reads on port B
   assign vtab.ce = i_ce;
   assign vtab.raddr_a = i_frame_vid;
   assign vtab.raddr_b = cmd_index;
   always_comb begin
      vtab.we = 1'b0;
      vtab.waddr = cmd_index;
      vtab.wdata = cmd_entry;
      if (state == ST_INIT) begin
         vtab.we = 1'b1;
         vtab.waddr = init_addr;
         vtab.wdata = mvl_pkg::ENTRY_RESET;
      end else if (state == ST_WRITE) begin
         vtab.we = 1'b1;
      end
   end

   // Command sequencing
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (i_vlan_cmd_wr) begin
               case (i_vlan_table_command)
                  mvl_pkg::MVL_CMD_INIT: next_state = ST_INIT;
                  mvl_pkg::MVL_CMD_WRITE: next_state = ST_WRITE;
                  mvl_pkg::MVL_CMD_READ: next_state = ST_RD_ADDR;
                  default: next_state = ST_IDLE;
               endcase
            end
         end
         ST_INIT: begin
            if (init_addr == AW'(mvl_pkg::VLAN_DEPTH - 1)) begin
               next_state = ST_IDLE;
            end
         end
         ST_WRITE: next_state = ST_IDLE;
         ST_RD_ADDR: next_state = ST_RD_CAP;
         ST_RD_CAP: next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Reset starts a full table sweep
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         state <= ST_INIT;
      end else if (i_ce) begin
         state <= next_state;
      end
   end

   // Sweep address
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         init_addr <= 12'h000;
      end else if (i_ce) begin
         if (state == ST_INIT) begin
            init_addr <= init_addr + 12'h001;
         end else begin
            init_addr <= 12'h000;
         end
      end
   end

   // Command operands latched when a command is accepted
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         cmd_index <= 12'h000;
         cmd_entry <= mvl_pkg::ENTRY_RESET;
      end else if (i_ce && state == ST_IDLE && i_vlan_cmd_wr) begin
         cmd_index <= i_vlan_index;
         cmd_entry <= {i_vlan_flags, i_member_port_mask};
      end
   end

   // Command field shows the busy command, idle when free
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_vlan_table_command <= mvl_pkg::MVL_CMD_INIT;
      end else if (i_ce) begin
         case (next_state)
            ST_IDLE: o_vlan_table_command <= mvl_pkg::MVL_CMD_IDLE;
            ST_INIT: o_vlan_table_command <= mvl_pkg::MVL_CMD_INIT;
            ST_WRITE: o_vlan_table_command <= mvl_pkg::MVL_CMD_WRITE;
            default: o_vlan_table_command <= mvl_pkg::MVL_CMD_READ;
         endcase
      end
   end

   // Read result, valid when the command field returns idle
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_vlan_rd_index <= 12'h000;
         o_vlan_rd_mask <= 11'h7FF;
         o_vlan_rd_flags <= 4'h0;
      end else if (i_ce && state == ST_RD_CAP) begin
         o_vlan_rd_index <= cmd_index;
         o_vlan_rd_mask <= vtab.rdata_b[NPORTS-1:0];
         o_vlan_rd_flags <= vtab.rdata_b[EW-1:NPORTS];
      end
   end

   // Frame stage one, waiting for table data
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         f1_valid <= 1'b0;
         f1_init <= 1'b0;
         f1_vid <= 12'h000;
         f1_port <= 4'h0;
         f1_sel <= mvl_pkg::SEL_NONE;
         f1_ovr <= 13'h0000;
         f1_mask <= 12'h000;
      end else if (i_ce) begin
         f1_valid <= i_frame_valid;
         f1_init <= (state == ST_INIT);
         f1_vid <= i_frame_vid;
         f1_port <= i_physical_ingress_port;
         f1_sel <= i_filter_id_select;
         f1_ovr <= i_override_filter_id_value;
         f1_mask <= i_vid_merge_mask;
      end
   end

   // During the sweep every lookup sees the default entry
   assign f1_entry = f1_init ? mvl_pkg::ENTRY_RESET : vtab.rdata_a;
   always_comb begin
      f1_members = f1_entry[NPORTS-1:0];
      f1_members[HOST_PORT] = 1'b1;
   end

   // Frame results
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_res_valid <= 1'b0;
         o_dmac_fid <= 13'h0000;
         o_learn_fid <= 13'h0000;
         o_member_port_mask <= 11'h7FF;
         o_mirror_on_receive <= 1'b0;
         o_learning_off_flag <= 1'b0;
         o_private_flag <= 1'b0;
         o_ingress_drop <= 1'b0;
      end else if (i_ce) begin
         o_res_valid <= f1_valid;
         o_dmac_fid <= calc_dmac;
         o_learn_fid <= calc_smac;
         o_member_port_mask <= f1_members;
         o_mirror_on_receive <= f1_entry[NPORTS + mvl_pkg::FLG_MIRROR];
         o_learning_off_flag <= f1_entry[NPORTS + mvl_pkg::FLG_LEARN_OFF];
         o_private_flag <= f1_entry[NPORTS + mvl_pkg::FLG_PRIVATE];
         o_ingress_drop <= f1_valid && f1_entry[NPORTS + mvl_pkg::FLG_MEMBER_CHK] &&
            !(in_range(f1_port) && f1_members[f1_port]);
      end
   end

   // Limit decision for the offered learn
   assign counted = !i_learn_locked && !i_learn_ip_multicast_entry;
   assign refuse = i_learn_valid && counted &&
      (!in_range(i_learn_port) || cnt[i_learn_port] >= lim_of(i_learn_port));
   assign inc_new = i_learn_valid && counted && !refuse;
   assign dec_old = i_learn_valid && counted && i_learn_move;

   // Net change of each port count this cycle
   always_comb begin
      for (int p = 0; p < NPORTS; p++) begin
         next_cnt[p] = cnt[p];
         if (inc_new && i_learn_port == mvl_pkg::PORT_W'(p)) begin
            next_cnt[p] = next_cnt[p] + CNT_W'(1);
         end
         if (dec_old && i_learn_old_port == mvl_pkg::PORT_W'(p) && next_cnt[p] != '0) begin
            next_cnt[p] = next_cnt[p] - CNT_W'(1);
         end
         if (i_remove_valid && i_remove_port == mvl_pkg::PORT_W'(p) &&
            next_cnt[p] != '0) begin
            next_cnt[p] = next_cnt[p] - CNT_W'(1);
         end
      end
   end

   // Port entry counters
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         for (int p = 0; p < NPORTS; p++) begin
            cnt[p] <= '0;
         end
      end else if (i_ce) begin
         for (int p = 0; p < NPORTS; p++) begin
            cnt[p] <= next_cnt[p];
         end
      end
   end

   always_comb begin
      for (int p = 0; p < NPORTS; p++) begin
         o_port_entry_count[p*CNT_W +: CNT_W] = cnt[p];
      end
   end

   // Learn verdict and frame actions
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_learn_done <= 1'b0;
         o_learn_accept <= 1'b0;
         o_learn_refuse <= 1'b0;
         o_move_delete <= 1'b0;
         o_limit_copy_host <= 1'b0;
         o_limit_withhold_fwd <= 1'b0;
      end else if (i_ce) begin
         o_learn_done <= i_learn_valid;
         o_learn_accept <= i_learn_valid && !refuse;
         o_learn_refuse <= refuse;
         o_move_delete <= refuse && i_learn_move;
         o_limit_copy_host <= refuse && !i_learn_host &&
            in_range(i_learn_port) && i_limit_copy[i_learn_port];
         o_limit_withhold_fwd <= refuse && !i_learn_host &&
            in_range(i_learn_port) && i_limit_discard[i_learn_port];
      end
   end

   // Global count of refused learns, wraps
   always_ff @(posedge i_clk) begin
      if (!i_resetn) begin
         o_learn_discard_counter <= 32'h00000000;
      end else if (i_ce && refuse) begin
         o_learn_discard_counter <= o_learn_discard_counter + 32'h00000001;
      end
   end
endmodule : mvl_top

/* shared/mvl_pkg.sv */
package mvl_pkg;
   // Table geometry
   localparam int VID_W = 12;
   localparam int FID_W = 13;
   localparam int NPORTS = 11;
   localparam int PORT_W = 4;
   localparam int VLAN_DEPTH = 4096;
   localparam int HOST_PORT = 10;
   localparam int CNT_W = 12;
   localparam int DISC_W = 32;
   // VLAN entry layout: flags above member mask
   localparam int FLAG_W = 4;
   localparam int ENTRY_W = NPORTS + FLAG_W;
   localparam int FLG_MIRROR = 0;
   localparam int FLG_MEMBER_CHK = 1;
   localparam int FLG_LEARN_OFF = 2;
   localparam int FLG_PRIVATE = 3;
   localparam logic [ENTRY_W-1:0] ENTRY_RESET = 15'h07FF;
   // VLAN table command field
   typedef enum logic [1:0] {
      MVL_CMD_IDLE = 2'b00,
      MVL_CMD_READ = 2'b01,
      MVL_CMD_WRITE = 2'b10,
      MVL_CMD_INIT = 2'b11
   } mvl_cmd_e;
   // Filter-id select codes
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_DMAC = 2'h1;
   localparam logic [1:0] SEL_SMAC = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;
   // Scan operations seen by the age-search filter
   localparam logic [1:0] SCAN_OTHER = 2'h0;
   localparam logic [1:0] SCAN_AGE = 2'h1;
   localparam logic [1:0] SCAN_GET_NEXT = 2'h2;
endpackage : mvl_pkg

/* shared/mvl_ram_if.sv */
`timescale 1ns/10ps
// Write port plus two registered read ports of a table memory
interface mvl_ram_if #(parameter int W = 8, parameter int AW = 4);
   logic ce;
   logic we;
   logic [AW-1:0] waddr;
   logic [W-1:0] wdata;
   logic [AW-1:0] raddr_a;
   logic [W-1:0] rdata_a;
   logic [AW-1:0] raddr_b;
   logic [W-1:0] rdata_b;
   modport ram (input ce, we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
   modport user (output ce, we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface : mvl_ram_if

/* verification/mvl_top_monitor.sv */
`timescale 1ns/10ps
module mvl_top_monitor #(
   parameter int NPORTS = 11,
   parameter int CNT_W = 12,
   parameter int HOST_PORT = 10
) (
   input logic i_clk,
   input logic i_resetn,
   input logic i_ce,
   input logic i_age_search_filter_ena,
   input logic i_filt_port_ena,
   input logic [3:0] i_filt_port,
   input logic i_scan_valid,
   input logic [1:0] i_scan_op,
   input logic [3:0] i_scan_port,
   input logic o_scan_valid,
   input logic o_scan_act,
   input logic i_frame_valid,
   input logic [1:0] i_filter_id_select,
   input logic [12:0] i_override_filter_id_value,
   input logic o_res_valid,
   input logic [12:0] o_dmac_fid,
   input logic [12:0] o_learn_fid,
   input logic [NPORTS-1:0] o_member_port_mask,
   input logic i_learn_valid,
   input logic o_learn_done,
   input logic o_learn_accept,
   input logic o_learn_refuse,
   input logic o_move_delete,
   input logic o_limit_copy_host,
   input logic [31:0] o_learn_discard_counter,
   input logic i_vlan_cmd_wr,
   input logic [1:0] i_vlan_table_command,
   input logic [1:0] o_vlan_table_command
);
   // One clock, sync reset
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Scans
   a_scan_answer: assert property (i_ce && i_scan_valid |=> o_scan_valid)
      else $error("scan unanswered");
   a_scan_unfiltered: assert property (i_ce && i_scan_valid && (!i_age_search_filter_ena
      || i_scan_op == mvl_pkg::SCAN_OTHER) |=> o_scan_act)
      else $error("unfiltered scan idle");
   a_scan_port_miss: assert property (i_ce && i_scan_valid && i_age_search_filter_ena
      && i_scan_op != mvl_pkg::SCAN_OTHER && i_filt_port_ena
      && i_scan_port != i_filt_port |=> !o_scan_act)
      else $error("port miss acted on");
   // Frames
   a_override_both: assert property (i_ce && i_frame_valid
      && i_filter_id_select == mvl_pkg::SEL_BOTH ##1 i_ce |=> o_res_valid
      && o_dmac_fid == $past(i_override_filter_id_value, 2)
      && o_learn_fid == $past(i_override_filter_id_value, 2))
      else $error("override unused");
   a_computed_top: assert property (i_ce && i_frame_valid
      && i_filter_id_select == mvl_pkg::SEL_NONE ##1 i_ce
      |=> !o_dmac_fid[12] && !o_learn_fid[12])
      else $error("id top bit set");
   a_host_member: assert property (o_res_valid |-> o_member_port_mask[HOST_PORT])
      else $error("host not member");
   // Learn limit
   a_learn_answer: assert property (i_ce && i_learn_valid
      |=> o_learn_done && (o_learn_accept != o_learn_refuse))
      else $error("bad learn answer");
   a_action_refuse: assert property (o_limit_copy_host || o_move_delete
      |-> o_learn_refuse)
      else $error("action unrefused");
   a_discard_count: assert property (o_learn_refuse
      |-> o_learn_discard_counter == $past(o_learn_discard_counter) + 1'b1)
      else $error("discard not counted");
   // VLAN commands
   a_write_walk: assert property (i_ce && i_vlan_cmd_wr && o_vlan_table_command == 2'h0
      && i_vlan_table_command == mvl_pkg::MVL_CMD_WRITE
      |=> o_vlan_table_command == 2'h2 ##1 o_vlan_table_command == 2'h0)
      else $error("bad write walk");
   a_read_walk: assert property (i_ce && i_vlan_cmd_wr && o_vlan_table_command == 2'h0
      && i_vlan_table_command == mvl_pkg::MVL_CMD_READ
      |=> (o_vlan_table_command == 2'h1) [*2] ##1 o_vlan_table_command == 2'h0)
      else $error("bad read walk");
endmodule : mvl_top_monitor

bind mvl_top mvl_top_monitor #(.NPORTS(NPORTS), .CNT_W(CNT_W), .HOST_PORT(HOST_PORT))
   u_mvl_top_monitor (.*);

/* verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
   localparam int CW = mvl_pkg::CNT_W;
   logic i_clk, i_resetn, i_ce, i_age_search_filter_ena, i_filt_port_ena, i_filt_fid_ena;
   logic i_filt_dom_ena, i_filt_dom, i_scan_valid, i_scan_dom, i_frame_valid, i_map_we;
   logic i_learn_valid, i_learn_host, i_learn_locked, i_learn_ip_multicast_entry, i_learn_move;
   logic i_remove_valid, i_vlan_cmd_wr, o_scan_valid, o_scan_act, o_res_valid;
   logic o_mirror_on_receive, o_learning_off_flag, o_private_flag, o_ingress_drop;
   logic o_learn_done, o_learn_accept, o_learn_refuse, o_move_delete;
   logic o_limit_copy_host, o_limit_withhold_fwd;
   logic [1:0] i_scan_op, i_filter_id_select, i_vlan_table_command, o_vlan_table_command;
   logic [3:0] i_filt_port, i_scan_port, i_physical_ingress_port;
   logic [3:0] i_learn_port, i_learn_old_port, i_remove_port;
   logic [12:0] i_filt_fid, i_scan_fid, i_override_filter_id_value;
   logic [12:0] o_dmac_fid, o_learn_fid;
   logic [11:0] i_frame_vid, i_vid_merge_mask, i_map_vid;
   logic [11:0] i_mapped_filter_id_value, i_vlan_index, o_vlan_rd_index;
   logic [10:0] o_member_port_mask, i_limit_copy, i_limit_discard;
   logic [10:0] i_member_port_mask, o_vlan_rd_mask;
   logic [11*CW-1:0] i_port_entry_limit, o_port_entry_count;
   logic [31:0] o_learn_discard_counter;
   logic [3:0] i_vlan_flags, o_vlan_rd_flags;
   int miscompares = 0;
   int checked = 0;

   mvl_top u_mvl_top (.*);

   // 100 MHz clock
   initial i_clk = 1'b0;
   always #5 i_clk = ~i_clk;

   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wrap_up();
      if (miscompares == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : wrap_up

   // Bounded wait for idle
   task idle();
      for (int n = 0; n < 5000; n++) begin
         #1;
         if (o_vlan_table_command === 2'h0) return;
         @(posedge i_clk);
      end
      chk(o_vlan_table_command, 2'h0);
   endtask : idle

   task vcmd(input logic [1:0] cmd, input logic [11:0] idx, input logic [10:0] msk,
         input logic [3:0] flg);
      @(posedge i_clk);
      {i_vlan_table_command, i_vlan_index, i_member_port_mask, i_vlan_flags, i_vlan_cmd_wr}
         <= {cmd, idx, msk, flg, 1'b1};
      @(posedge i_clk);
      i_vlan_cmd_wr <= 1'b0;
      idle();
   endtask : vcmd

   task map(input logic [11:0] vid, input logic [11:0] val);
      @(posedge i_clk);
      {i_map_vid, i_mapped_filter_id_value, i_map_we} <= {vid, val, 1'b1};
      @(posedge i_clk);
      i_map_we <= 1'b0;
   endtask : map

   // Results two edges after intake
   task frame(input logic [11:0] vid, input logic [3:0] port, input logic [1:0] sel);
      @(posedge i_clk);
      {i_frame_vid, i_physical_ingress_port, i_filter_id_select, i_frame_valid}
         <= {vid, port, sel, 1'b1};
      @(posedge i_clk);
      i_frame_valid <= 1'b0;
      @(posedge i_clk);
      #1;
      chk(o_res_valid, 1'b1);
   endtask : frame

   // Flags f: host, locked, ip_multicast_entry, move, expected accept
   task learn(input logic [3:0] port, input logic [3:0] old, input logic [4:0] f);
      @(posedge i_clk);
      {i_learn_host, i_learn_locked, i_learn_ip_multicast_entry, i_learn_move} <= f[4:1];
      {i_learn_port, i_learn_old_port, i_learn_valid} <= {port, old, 1'b1};
      @(posedge i_clk);
      i_learn_valid <= 1'b0;
      #1;
      chk(o_learn_accept, f[0]);
      chk(o_learn_refuse, !f[0]);
   endtask : learn

   task cnt(input int p, input logic [11:0] exp);
      chk(o_port_entry_count[p*CW+:CW], exp);
   endtask : cnt

   task scan(input logic [1:0] op, input logic [3:0] port, input logic [12:0] fid,
         input logic dom, input logic act);
      @(posedge i_clk);
      {i_scan_op, i_scan_port, i_scan_fid, i_scan_dom, i_scan_valid}
         <= {op, port, fid, dom, 1'b1};
      @(posedge i_clk);
      i_scan_valid <= 1'b0;
      #1;
      chk(o_scan_act, act);
   endtask : scan

   // Main sequence
   initial begin
      // Strobes and filter enables start low, i_ce high; per-event data is set with its strobe
      {i_resetn, i_age_search_filter_ena, i_filt_port_ena, i_filt_fid_ena, i_filt_dom_ena,
         i_scan_valid, i_frame_valid, i_map_we, i_learn_valid, i_remove_valid,
         i_vlan_cmd_wr} <= '0;
      i_ce <= 1'b1;
      i_vid_merge_mask <= 12'h00F;
      i_override_filter_id_value <= 13'h1ABC;
      i_port_entry_limit <= {{8{12'h005}}, 12'h002, {2{12'h005}}};
      i_limit_copy <= 11'h004;
      i_limit_discard <= 11'h004;
      repeat (5) @(posedge i_clk);
      i_resetn <= 1'b1;
      idle();
      map(12'h123, 12'h000);
      frame(12'h123, 4'h1, 2'h0);
      chk(o_member_port_mask, 11'h7FF);
      chk({o_mirror_on_receive, o_learning_off_flag, o_private_flag}, 3'h0);
      // All select codes, map zero then set
      for (int m = 0; m < 2; m++) begin
         if (m == 1) map(12'h123, 12'h055);
         for (int s = 0; s < 4; s++) begin
            frame(12'h123, 4'h1, s[1:0]);
            chk(o_dmac_fid, s[0] ? 13'h1ABC : (m && s == 0) ? 13'h0055 : 13'h0120);
            chk(o_learn_fid, s[1] ? 13'h1ABC : (m && s == 0) ? 13'h0055 : 13'h0120);
         end
      end
      vcmd(mvl_pkg::MVL_CMD_WRITE, 12'h123, 11'h0F5, 4'hA);
      vcmd(mvl_pkg::MVL_CMD_READ, 12'h123, 11'h000, 4'h0);
      chk({o_vlan_rd_index, o_vlan_rd_mask, o_vlan_rd_flags}, {12'h123, 11'h0F5, 4'hA});
      frame(12'h123, 4'h1, 2'h0);
      chk(o_member_port_mask, 11'h4F5);
      chk({o_mirror_on_receive, o_learning_off_flag, o_private_flag, o_ingress_drop}, 4'h3);
      frame(12'h123, 4'h0, 2'h0);
      chk(o_ingress_drop, 1'b0);
      vcmd(mvl_pkg::MVL_CMD_INIT, 12'h000, 11'h000, 4'h0);
      vcmd(mvl_pkg::MVL_CMD_READ, 12'h123, 11'h000, 4'h0);
      chk({o_vlan_rd_mask, o_vlan_rd_flags}, {11'h7FF, 4'h0});
      // Port 2 limit of two entries
      learn(4'h2, 4'h0, 5'h01);
      learn(4'h2, 4'h0, 5'h01);
      learn(4'h2, 4'h0, 5'h09);
      learn(4'h2, 4'h0, 5'h05);
      cnt(2, 12'h002);
      learn(4'h2, 4'h0, 5'h00);
      chk({o_limit_copy_host, o_limit_withhold_fwd}, 2'h3);
      learn(4'h2, 4'h0, 5'h10);
      chk({o_limit_copy_host, o_limit_withhold_fwd}, 2'h0);
      chk(o_learn_discard_counter, 32'h0000_0002);
      @(posedge i_clk);
      {i_remove_port, i_remove_valid} <= {4'h2, 1'b1};
      @(posedge i_clk);
      i_remove_valid <= 1'b0;
      #1;
      cnt(2, 12'h001);
      learn(4'h3, 4'h0, 5'h01);
      learn(4'h2, 4'h3, 5'h03);
      cnt(2, 12'h002);
      cnt(3, 12'h000);
      learn(4'h3, 4'h0, 5'h01);
      learn(4'h2, 4'h3, 5'h02);
      chk(o_move_delete, 1'b1);
      cnt(3, 12'h000);
      chk(o_learn_discard_counter, 32'h0000_0003);
      // Filter port 2, id 120, domain 1; op 1 age, 2 next
      {i_age_search_filter_ena, i_filt_port_ena, i_filt_port, i_filt_fid_ena, i_filt_fid,
         i_filt_dom_ena, i_filt_dom} <= {2'h3, 4'h2, 1'b1, 13'h0120, 2'h3};
      scan(2'h1, 4'h2, 13'h0120, 1'b1, 1'b1);
      scan(2'h2, 4'h3, 13'h0120, 1'b1, 1'b0);
      scan(2'h1, 4'h2, 13'h0120, 1'b0, 1'b0);
      scan(2'h1, 4'h2, 13'h0121, 1'b1, 1'b0);
      scan(2'h0, 4'h3, 13'h0121, 1'b0, 1'b1);
      i_age_search_filter_ena <= 1'b0;
      scan(2'h1, 4'h3, 13'h0000, 1'b0, 1'b1);
      wrap_up();
   end

   // Watchdog against a hang
   initial begin
      #300000;
      miscompares++;
      wrap_up();
   end
endmodule : testbench
